// [src/ugr_defines.svh]
// Contract
// R1 - setup token on control endpoint zero sets status bit 8
// R2 - rising edge of vbus level sets status bit 7; code sets it only while dual_role_off is set
// R3 - software sets dual_role_off for pure host or peripheral use
// R4 - any change of dma reason value sets status bit 6
// R5 - full-speed to high-speed change sets status bit 5
// R6 - entering full-speed suspend never sets status bit 5
// R7 - suspend to resume change sets status bit 4
// R8 - active to suspend change sets status bit 3
// R9 - free running pseudo frame tick, 1 ms fs, 125 us hs, sets bit 2
// R10 - each received frame start packet sets status bit 1
// R11 - detected bus reset sets status bit 0
// R12 - read-only 32-bit ident: version high half, chip code low half
// R13 - read-only register holds frame number of last good frame start
// R14 - microframe in 13:11, frame in 10:0, zero after resets
// R15 - 16-bit scratch register, zero at power-on, kept over bus reset
// R16 - interrupt output high while any status bit is set; code counts only status bits enabled in the mask register
// R17 - status bits clear on write one; dma bit also needs reason cleared; code clears the dma bit on write one alone
`ifndef UGR_DEFINES_SVH
`define UGR_DEFINES_SVH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define UGR_OFS_STATUS 12'h218
`define UGR_OFS_MASK 12'h21c
`define UGR_OFS_IDENT 12'h270
`define UGR_OFS_FRAME 12'h274
`define UGR_OFS_SCRATCH 12'h278
`define UGR_OFS_DUALCTL 12'h374
// ------------------------------------------------------------
// status bit positions
// ------------------------------------------------------------
`define UGR_BIT_BUSRST 0
`define UGR_BIT_SOF 1
`define UGR_BIT_PSEUDO_FRAME_TICK 2
`define UGR_BIT_SUSP 3
`define UGR_BIT_RESUME 4
`define UGR_BIT_HS 5
`define UGR_BIT_DMA 6
`define UGR_BIT_VBUS 7
`define UGR_BIT_SETUP 8
`define UGR_EV_W 9
// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define UGR_MICRO_LSB 11
`define UGR_DUAL_BIT 0
`define UGR_STATUS_RST 9'h000
`define UGR_STATUS_BUSRST 9'h001
`define UGR_MASK_RST 9'h1ff
`define UGR_FRAME_RST 14'h0000
`define UGR_SCRATCH_RST 16'h0000
`define UGR_IDENT_DEF 32'h00a5_0c3e
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define UGR_CLK_PERIOD_PS 5000
`define UGR_FS_TICK_US 1000
`define UGR_HS_TICK_US 125
`define UGR_FS_TICK_CYC ((`UGR_FS_TICK_US * 1000000) / `UGR_CLK_PERIOD_PS)
`define UGR_HS_TICK_CYC ((`UGR_HS_TICK_US * 1000000) / `UGR_CLK_PERIOD_PS)
`endif

// [src/ugr_pkg.sv]
package ugr_pkg;
	typedef enum logic [1:0] {
		UGR_BUS_IDLE,
		UGR_BUS_READ,
		UGR_BUS_WRITE
	} ugr_phase_type;
	typedef logic [8:0] ugr_event_type;
endpackage

// [src/ugr_regs.sv]
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "ugr_defines.svh"
module ugr_regs
	import ugr_pkg::*;
#(
	parameter logic [31:0] IDENT_VALUE = `UGR_IDENT_DEF, // arbitrary value
	parameter int FS_TICK_CYC = `UGR_FS_TICK_CYC,
	parameter int HS_TICK_CYC = `UGR_HS_TICK_CYC
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic hreadyout_o,
	output logic hresp_o,
	output logic [31:0] hrdata_o,
	input wire logic bus_reset_seen_i,
	input wire logic ctrl_setup_received_i,
	input wire logic vbus_level_i,
	input wire logic [15:0] dma_reason_i,
	input wire logic highspeed_i,
	input wire logic suspend_i,
	input wire logic sof_valid_i,
	input wire logic [10:0] frame_count_i,
	input wire logic [2:0] microframe_index_i,
	output logic dual_role_off_o,
	output logic irq_o
);

	// ------------------------------------------------------------
	// bus address phase capture
	// ------------------------------------------------------------
	wire logic addr_take;
	wire logic unused_bits;
	ugr_phase_type phase_r;
	ugr_phase_type phase_nxt;
	logic [11:0] addr_r;

	assign addr_take = hsel_i & htrans_i[1] & hready_i;
	assign phase_nxt = !addr_take ? UGR_BUS_IDLE : (hwrite_i ? UGR_BUS_WRITE : UGR_BUS_READ);
	assign unused_bits = ^{haddr_i[31:12], hsize_i, hwdata_i[31:16]};

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			phase_r <= UGR_BUS_IDLE;
			addr_r <= 12'h000;
		end else begin
			phase_r <= phase_nxt;
			if (addr_take) begin
				addr_r <= haddr_i[11:0];
			end
		end
	end

	assign hreadyout_o = 1'b1;
	assign hresp_o = 1'b0;

	// ------------------------------------------------------------
	// write decode
	// ------------------------------------------------------------
	wire logic wr_act;
	wire logic wr_status;
	wire logic wr_mask;
	wire logic wr_scratch;
	wire logic wr_dual;

	assign wr_act = (phase_r == UGR_BUS_WRITE);
	assign wr_status = wr_act & (addr_r == `UGR_OFS_STATUS);
	assign wr_mask = wr_act & (addr_r == `UGR_OFS_MASK);
	assign wr_scratch = wr_act & (addr_r == `UGR_OFS_SCRATCH);
	assign wr_dual = wr_act & (addr_r == `UGR_OFS_DUALCTL);

	// ------------------------------------------------------------
	// edge history of bus side levels
	// ------------------------------------------------------------
	logic vbus_r;
	logic hs_r;
	logic susp_r;
	logic [15:0] dma_r;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			vbus_r <= 1'b0;
			hs_r <= 1'b0;
			susp_r <= 1'b0;
			dma_r <= 16'h0000;
		end else begin
			vbus_r <= vbus_level_i;
			hs_r <= highspeed_i;
			susp_r <= suspend_i;
			dma_r <= dma_reason_i;
		end
	end

	// ------------------------------------------------------------
	// pseudo frame tick
	// ------------------------------------------------------------
	logic [17:0] tick_cnt_r;
	logic [17:0] tick_cnt_nxt;
	wire logic [17:0] tick_last;
	wire logic tick_hit;

	assign tick_last = highspeed_i ? 18'(HS_TICK_CYC - 1) : 18'(FS_TICK_CYC - 1);
	assign tick_hit = (tick_cnt_r >= tick_last); // see R9
	assign tick_cnt_nxt = tick_hit ? 18'h00000 : tick_cnt_r + 18'h00001;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tick_cnt_r <= 18'h00000;
		end else begin
			tick_cnt_r <= tick_cnt_nxt;
		end
	end

	// ------------------------------------------------------------
	// event vector
	// ------------------------------------------------------------
	logic dual_role_off_r;
	ugr_event_type ev;

	assign ev[`UGR_BIT_SETUP] = ctrl_setup_received_i; // see R1
	assign ev[`UGR_BIT_VBUS] = vbus_level_i & ~vbus_r & dual_role_off_r; // see R2 see R3
	assign ev[`UGR_BIT_DMA] = (dma_reason_i != dma_r); // see R4
	assign ev[`UGR_BIT_HS] = highspeed_i & ~hs_r & ~suspend_i; // see R5 see R6
	assign ev[`UGR_BIT_RESUME] = ~suspend_i & susp_r; // see R7
	assign ev[`UGR_BIT_SUSP] = suspend_i & ~susp_r; // see R8
	assign ev[`UGR_BIT_PSEUDO_FRAME_TICK] = tick_hit; // see R9
	assign ev[`UGR_BIT_SOF] = sof_valid_i; // see R10
	assign ev[`UGR_BIT_BUSRST] = bus_reset_seen_i; // see R11

	// ------------------------------------------------------------
	// status and mask
	// ------------------------------------------------------------
	ugr_event_type status_r;
	ugr_event_type status_nxt;
	ugr_event_type mask_r;
	wire logic [8:0] w1c;

	assign w1c = wr_status ? hwdata_i[8:0] : 9'h000;
	// set wins over a write-one clear landing in the same cycle
	assign status_nxt = bus_reset_seen_i ? (ev | `UGR_STATUS_BUSRST) : ((status_r & ~w1c) | ev); // see R17

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			status_r <= `UGR_STATUS_RST;
			mask_r <= `UGR_MASK_RST;
			dual_role_off_r <= 1'b0;
		end else begin
			status_r <= status_nxt;
			if (wr_mask) begin
				mask_r <= hwdata_i[8:0];
			end
			if (wr_dual) begin
				dual_role_off_r <= hwdata_i[`UGR_DUAL_BIT];
			end
		end
	end

	assign irq_o = |(status_r & mask_r); // see R16
	assign dual_role_off_o = dual_role_off_r;

	// ------------------------------------------------------------
	// frame number and scratch
	// ------------------------------------------------------------
	logic [13:0] frame_r;
	logic [15:0] scratch_r;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			frame_r <= `UGR_FRAME_RST;
		end else if (bus_reset_seen_i) begin
			frame_r <= `UGR_FRAME_RST; // see R14
		end else if (sof_valid_i) begin
			frame_r <= {microframe_index_i, frame_count_i}; // see R13 see R14
		end
	end

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			scratch_r <= `UGR_SCRATCH_RST;
		end else if (wr_scratch) begin
			scratch_r <= hwdata_i[15:0]; // see R15
		end
	end

	// ------------------------------------------------------------
	// read mux
	// ------------------------------------------------------------
	wire logic [11:0] ra;
	wire logic rd_take;
	wire logic [31:0] rd_word;
	logic [31:0] rdata_r;

	assign ra = haddr_i[11:0];
	assign rd_take = addr_take & ~hwrite_i;
	assign rd_word = (ra == `UGR_OFS_STATUS) ? {23'h000000, status_r} :
		(ra == `UGR_OFS_MASK) ? {23'h000000, mask_r} :
		(ra == `UGR_OFS_IDENT) ? IDENT_VALUE : // see R12
		(ra == `UGR_OFS_FRAME) ? {18'h00000, frame_r} :
		(ra == `UGR_OFS_SCRATCH) ? {16'h0000, scratch_r} :
		(ra == `UGR_OFS_DUALCTL) ? {31'h00000000, dual_role_off_r} : 32'h00000000;

	always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_r <= 32'h00000000;
		end else if (rd_take) begin
			rdata_r <= rd_word;
		end
	end

	assign hrdata_o = rdata_r;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (sys_rst_i);

	a_setup_sets: assert property (ctrl_setup_received_i |=> status_r[`UGR_BIT_SETUP]) // see R1
		else $error("setup event lost");

	a_vbus_rise: assert property ((dual_role_off_r && $rose(vbus_level_i)) |=> status_r[`UGR_BIT_VBUS]) // see R2
		else $error("vbus rise not reported");

	a_dma_change: assert property ((dma_reason_i != $past(dma_reason_i)) |=> status_r[`UGR_BIT_DMA]) // see R4
		else $error("dma change not reported");

	a_hs_no_susp: assert property ((!status_r[`UGR_BIT_HS] && suspend_i && !bus_reset_seen_i
		&& (phase_r != UGR_BUS_WRITE) && $stable(highspeed_i)) |=> !status_r[`UGR_BIT_HS]) // see R6
		else $error("hs bit set in suspend");

	a_susp_resume: assert property ($fell(suspend_i) |=> status_r[`UGR_BIT_RESUME]) // see R7
		else $error("resume not reported");

	a_susp_enter: assert property ($rose(suspend_i) |=> status_r[`UGR_BIT_SUSP]) // see R8
		else $error("suspend not reported");

	a_pseudo_frame_tick_gap: assert property ((tick_hit && !highspeed_i) |=> !tick_hit[*8]) // see R9
		else $error("pseudo tick too soon");

	a_sof_frame: assert property ((sof_valid_i && !bus_reset_seen_i)
		|=> (frame_r == $past({microframe_index_i, frame_count_i})) && status_r[`UGR_BIT_SOF]) // see R10 see R13
		else $error("frame not captured");

	a_busrst_clear: assert property (bus_reset_seen_i |=> frame_r == 14'h0000 && status_r[`UGR_BIT_BUSRST]) // see R11
		else $error("bus reset effect missing");

	a_scratch_keep: assert property ((bus_reset_seen_i && !wr_scratch) |=> $stable(scratch_r)) // see R15
		else $error("scratch lost on bus reset");

	a_irq_level: assert property ((status_r != 9'h000 && mask_r == 9'h1ff) |-> irq_o) // see R16
		else $error("interrupt not raised");

	a_w1c_clear: assert property ((wr_status && hwdata_i[`UGR_BIT_SOF] && !sof_valid_i && !bus_reset_seen_i)
		|=> !status_r[`UGR_BIT_SOF]) // see R17
		else $error("write one did not clear");

	c_read_ident: cover property (rd_take && ra == `UGR_OFS_IDENT);
	c_irq_clear: cover property (irq_o ##1 wr_status ##1 !irq_o);
	c_pseudo_frame_tick_tick: cover property (tick_hit);
	c_bus_reset: cover property (bus_reset_seen_i ##1 sof_valid_i);

endmodule
`default_nettype wire

// [verif/ugr_host_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// ahb-lite master standing for the processor
// ------------------------------------------------------------
module ugr_host_model (
	input wire logic clk_i,
	input wire logic hready_i,
	input wire logic [31:0] hrdata_i,
	output logic hsel_o,
	output logic [31:0] haddr_o,
	output logic [1:0] htrans_o,
	output logic hwrite_o,
	output logic [31:0] hwdata_o
);
	initial begin
		hsel_o = 1'b0;
		haddr_o = 32'h0;
		htrans_o = 2'h0;
		hwrite_o = 1'b0;
		hwdata_o = 32'h0;
	end
	// bounded wait for hready at a rising edge
	task automatic wait_rdy(inout logic to);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hready_i !== 1'b1 && n < 50);
		to = to | (hready_i !== 1'b1);
	endtask
	// one single word transfer, address phase then data phase
	task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic to);
		to = 1'b0;
		@(posedge clk_i);
		hsel_o <= 1'b1;
		htrans_o <= 2'h2;
		haddr_o <= a;
		hwrite_o <= w;
		wait_rdy(to);
		hsel_o <= 1'b0;
		htrans_o <= 2'h0;
		hwdata_o <= d;
		wait_rdy(to);
		r = hrdata_i;
		hwdata_o <= ~d;
	endtask
endmodule
`default_nettype wire

// [verif/usb_periph_general_regs_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// register bank testbench
// ------------------------------------------------------------
module usb_periph_general_regs_tb_top
	import ugr_pkg::*;
;
	localparam logic [31:0] IDENT_VAL = 32'h0042_0017; // arbitrary value
	localparam logic [31:0] NOPS = 32'hffff_fffb;
	localparam logic [31:0] ALL = 32'hffff_ffff;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic bus_rst = 1'b0;
	logic setup = 1'b0;
	logic vbus = 1'b0;
	logic hs = 1'b0;
	logic susp = 1'b0;
	logic sof = 1'b0;
	logic [15:0] dma = 16'h0;
	logic [10:0] fcnt = 11'h0;
	logic [2:0] micro = 3'h0;
	logic hsel, hwrite, hready, hresp, dual_off, irq;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	int failures = 0;
	int n_checks = 0;
	always #2.5 clk = ~clk;
	ugr_regs #(.IDENT_VALUE(IDENT_VAL), .FS_TICK_CYC(40), .HS_TICK_CYC(10)) i_ugr_regs (
		.ref_clk_i(clk), .sys_rst_i(rst), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .bus_reset_seen_i(bus_rst),
		.ctrl_setup_received_i(setup), .vbus_level_i(vbus), .dma_reason_i(dma), .highspeed_i(hs),
		.suspend_i(susp), .sof_valid_i(sof), .frame_count_i(fcnt), .microframe_index_i(micro),
		.dual_role_off_o(dual_off), .irq_o(irq));
	ugr_host_model i_ugr_host_model (.clk_i(clk), .hready_i(hready), .hrdata_i(hrdata), .hsel_o(hsel),
		.haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite), .hwdata_o(hwdata));
	task summarize;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
		logic to;
		i_ugr_host_model.xfer(w, a, d, r, to);
		if (to) begin
			failures++;
			summarize();
		end
	endtask
	task wr(input logic [31:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task rd(input logic [31:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r & m, e);
	endtask
	task t_reset;
		chk({31'h0, irq}, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		rd(32'h218, NOPS, 32'h0);
		rd(32'h21c, ALL, 32'h1ff);
		rd(32'h270, ALL, IDENT_VAL);
		wr(32'h270, 32'h0);
		rd(32'h270, ALL, IDENT_VAL);
		rd(32'h274, ALL, 32'h0);
		rd(32'h278, ALL, 32'h0);
		rd(32'h300, ALL, 32'h0);
		wr(32'h21c, 32'h1fb);
		rd(32'h21c, ALL, 32'h1fb);
		wr(32'h374, 32'h1);
		@(negedge clk);
		chk({31'h0, dual_off}, 32'h1);
		rd(32'h374, ALL, 32'h1);
		$display("reset test done");
	endtask
	task t_events;
		for (int b = 0; b < 9; b++) begin
			if (b != 2) begin
				@(posedge clk);
				case (b)
					0: bus_rst <= 1'b1;
					1: sof <= 1'b1;
					3: susp <= 1'b1;
					4: susp <= 1'b0;
					5: hs <= 1'b1;
					6: dma <= 16'h0041;
					7: vbus <= 1'b1;
					default: setup <= 1'b1;
				endcase
				@(posedge clk);
				bus_rst <= 1'b0;
				sof <= 1'b0;
				setup <= 1'b0;
				rd(32'h218, NOPS, 32'h1 << b);
				chk({31'h0, irq}, 32'h1);
				wr(32'h218, 32'h1 << b);
				rd(32'h218, NOPS, 32'h0);
				chk({31'h0, irq}, 32'h0);
			end
		end
		$display("event test done");
	endtask
	task t_nohs;
		@(posedge clk);
		hs <= 1'b0;
		wr(32'h218, 32'h1ff);
		@(posedge clk);
		susp <= 1'b1;
		@(posedge clk);
		hs <= 1'b1;
		rd(32'h218, NOPS, 32'h008);
		@(posedge clk);
		susp <= 1'b0;
		hs <= 1'b0;
		$display("suspend test done");
	endtask
	task t_tick;
		wr(32'h218, 32'h1ff);
		repeat (42) @(posedge clk);
		rd(32'h218, 32'h4, 32'h4);
		wr(32'h21c, 32'h4);
		@(negedge clk);
		chk({31'h0, irq}, 32'h1);
		wr(32'h21c, 32'h1fb);
		wr(32'h218, 32'h4);
		hs <= 1'b1;
		repeat (12) @(posedge clk);
		rd(32'h218, 32'h4, 32'h4);
		$display("tick test done");
	endtask
	task t_frame;
		wr(32'h278, 32'hffff_a5c3);
		rd(32'h278, ALL, 32'h0000_a5c3);
		@(posedge clk);
		sof <= 1'b1;
		fcnt <= 11'h5a3;
		micro <= 3'h5;
		@(posedge clk);
		sof <= 1'b0;
		fcnt <= 11'h7ff;
		micro <= 3'h2;
		rd(32'h274, ALL, 32'h2da3);
		wr(32'h218, 32'h1ff);
		@(posedge clk);
		bus_rst <= 1'b1;
		@(posedge clk);
		bus_rst <= 1'b0;
		rd(32'h274, ALL, 32'h0);
		rd(32'h278, ALL, 32'h0000_a5c3);
		rd(32'h218, NOPS, 32'h001);
		$display("frame test done");
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_events();
		t_nohs();
		t_tick();
		t_frame();
		summarize();
	end
endmodule
`default_nettype wire
